// File: design/lmu_pkg.sv
// Constants shared by the LED driver control logic
package lmu_pkg;

  // Register offsets
  localparam logic [7:0] OFS_LEVEL_FADE = 8'h00;
  localparam logic [7:0] OFS_SINK_EN = 8'h01;
  localparam logic [7:0] OFS_FLASH_SETUP = 8'h02;
  localparam logic [7:0] OFS_REG_VOLT = 8'h03;

  // Reset values
  localparam logic [7:0] RST_LEVEL_FADE = 8'h00;
  localparam logic [7:0] RST_SINK_EN = 8'h00;
  localparam logic [7:0] RST_FLASH_SETUP = 8'h10;
  localparam logic [7:0] RST_REG_VOLT = 8'h00;

  // Level and fade register fields
  localparam int FADE_RATE_MSB = 7;
  localparam int FADE_RATE_LSB = 6;
  localparam int FADE_EN_POS = 5;
  localparam int LEVEL_MSB = 4;
  localparam int LEVEL_LSB = 0;

  // Sink enable register fields
  localparam int SINK_EN_MSB = 3;
  localparam int SINK_EN_LSB = 0;
  localparam int NUM_SINKS = 4;

  // Flash setup register fields
  localparam int FLASH_TMO_EN_POS = 4;
  localparam int FLASH_CODE_MSB = 3;
  localparam int FLASH_CODE_LSB = 1;
  localparam int FLASH_RANGE_POS = 0;

  // Regulator voltage register fields
  localparam int REG_B_MSB = 6;
  localparam int REG_B_LSB = 4;
  localparam int REG_A_MSB = 3;
  localparam int REG_A_LSB = 0;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int FADE_UNIT_MS = 8;
  localparam int FADE_UNIT_CYCLES = CLK_HZ / 1000 * FADE_UNIT_MS;
  localparam int FLASH_TIMEOUT_MS = 1000;
  localparam int FLASH_TIMEOUT_CYCLES = CLK_HZ / 1000 * FLASH_TIMEOUT_MS;
  // Fade interval is (FADE_UNITS_MAX - rate code) units: 32, 24, 16, 8 ms
  localparam logic [2:0] FADE_UNITS_MAX = 3'h4;

  // Protection state of the pump output
  typedef enum logic [1:0] {
    LMU_PUMP_NORMAL,
    LMU_PUMP_LIMIT
  } lmu_pump_e;

endpackage

// File: design/lmu_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module lmu_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      meta <= i_async;
      s2 <= meta;
      s3 <= s2;
    end
  end

  // A bit changes only once the second and third stages agree
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sync <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          o_sync[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: design/lmu_flash_timer.sv
// Flash sink safety timer: trips after continuous activity
`timescale 1ns/1ps
`default_nettype none
module lmu_flash_timer #(
  parameter int TIMEOUT_CYCLES = lmu_pkg::FLASH_TIMEOUT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_active,
  input wire logic i_rearm,
  output logic o_tripped
);
  logic [23:0] cnt;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 24'h000000;
    end else if (!i_active || !i_enable || i_rearm) begin
      cnt <= 24'h000000;
    end else if (cnt != 24'(TIMEOUT_CYCLES - 1)) begin
      cnt <= cnt + 24'h000001;
    end
  end

  // Trip wins over a rearm in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tripped <= 1'b0;
    end else if (i_active && i_enable && cnt == 24'(TIMEOUT_CYCLES - 1)) begin
      o_tripped <= 1'b1;
    end else if (i_rearm) begin
      o_tripped <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/lmu_ctrl.sv
// LED driver control: registers, fade sequencer, fault handling, sleep
// Behaviour
// - Rate code 00..11 gives 32,24,16,8 ms
// - Fade steps equal old/new code difference
// - Enabled fade walks level one step per interval
// - Clearing fade enable applies programmed code at once
// - Fade disabled: new level applies immediately
// - Rate change mid-fade sets remaining step interval
// - Offset 0x00 holds rate, enable, level code
// - Sink carries level only while enabled
// - Over-temperature disables all outputs until cleared
// - Registers kept unchanged during thermal shutdown
// - Open-circuit sink output gets disabled
// - Over-voltage stops pump until indication clears
// - Current limit below 2V, leave above 2.5V
// - 300mA limit flash off, 1A flash on
// - Flash timeout turns sink off after 1s
// - Enable pin low resets all registers
// - Sink enables active high, default zero
// - All LEDs off enters sleep, stops pump
`timescale 1ns/1ps
`default_nettype none
module lmu_ctrl #(
  parameter int P_FADE_UNIT_CYCLES = lmu_pkg::FADE_UNIT_CYCLES,
  parameter int P_FLASH_TIMEOUT_CYCLES = lmu_pkg::FLASH_TIMEOUT_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Register port from the serial interface engine
  input wire logic I_WR_STB,
  input wire logic [7:0] I_WR_ADDR,
  input wire logic [7:0] I_WR_DATA,
  input wire logic [7:0] I_RD_ADDR,
  output logic [7:0] O_RD_DATA,
  // Asynchronous pins and analog indications
  input wire logic I_CHIP_EN,
  input wire logic I_FLASH_TRIGGER_PIN,
  input wire logic I_OVERTEMP_GUARD,
  input wire logic I_OUTPUT_OVERVOLTAGE_GUARD,
  input wire logic I_PUMP_OUTPUT_BELOW_2V,
  input wire logic I_PUMP_OUTPUT_ABOVE_2V5,
  input wire logic [3:0] I_SINK_OPEN,
  // Settings to the analog blocks
  output logic [4:0] O_BACKLIGHT_LEVEL_CODE,
  output logic [3:0] O_SINK_ON,
  output logic O_FLASH_SINK_OUTPUT,
  output logic [2:0] O_FLASH_SPOT_LEVEL_CODE,
  output logic O_FLASH_RANGE_SELECT,
  output logic [3:0] O_REG_A_VOLTAGE_CODE,
  output logic [2:0] O_REG_B_VOLTAGE_CODE,
  output logic O_PUMP_RUN,
  output logic O_PUMP_LIMIT_ACTIVE,
  output logic O_PUMP_ILIM_HIGH,
  output logic O_SLEEP,
  output logic O_FADE_ACTIVE,
  output logic O_FLASH_TIMED_OUT
);
  logic chip_en;
  logic flash_pin;
  logic overtemp;
  logic overvolt;
  logic below_2v;
  logic above_2v5;
  logic [3:0] sink_open;

  lmu_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_en (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async(I_CHIP_EN),
    .o_sync(chip_en)
  );

  lmu_sync #(.WIDTH(9), .RST_VAL(9'h000)) u_sync_pins (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async({I_FLASH_TRIGGER_PIN, I_OVERTEMP_GUARD, I_OUTPUT_OVERVOLTAGE_GUARD,
              I_PUMP_OUTPUT_BELOW_2V, I_PUMP_OUTPUT_ABOVE_2V5, I_SINK_OPEN}),
    .o_sync({flash_pin, overtemp, overvolt, below_2v, above_2v5, sink_open})
  );

  // Programmed register fields
  logic [1:0] fade_rate;
  logic fade_en;
  logic [4:0] backlight_level_code;
  logic [3:0] sink_enable_bits;
  logic flash_timeout_enable;
  logic [2:0] flash_spot_level_code;
  logic flash_range_select;
  logic [3:0] reg_a_voltage_code;
  logic [2:0] reg_b_voltage_code;

  // Fade sequencer state
  logic [4:0] applied_level;
  logic [21:0] step_cnt;
  logic [21:0] step_limit;
  logic fade_active;
  logic step_due;

  logic wr_level;
  logic wr_sink;
  logic wr_flash;
  logic wr_volt;

  assign wr_level = I_WR_STB && I_WR_ADDR == lmu_pkg::OFS_LEVEL_FADE;
  assign wr_sink = I_WR_STB && I_WR_ADDR == lmu_pkg::OFS_SINK_EN;
  assign wr_flash = I_WR_STB && I_WR_ADDR == lmu_pkg::OFS_FLASH_SETUP;
  assign wr_volt = I_WR_STB && I_WR_ADDR == lmu_pkg::OFS_REG_VOLT;

  assign fade_active = fade_en && applied_level != backlight_level_code;

  // Level and fade register; enable pin low restores defaults.
  // Overtemp never touches the registers, so settings come back after it.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      fade_rate <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::FADE_RATE_MSB:lmu_pkg::FADE_RATE_LSB];
      fade_en <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::FADE_EN_POS];
      backlight_level_code <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::LEVEL_MSB:lmu_pkg::LEVEL_LSB];
    end else if (!chip_en) begin
      fade_rate <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::FADE_RATE_MSB:lmu_pkg::FADE_RATE_LSB];
      fade_en <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::FADE_EN_POS];
      backlight_level_code <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::LEVEL_MSB:lmu_pkg::LEVEL_LSB];
    end else if (wr_level) begin
      fade_rate <= I_WR_DATA[lmu_pkg::FADE_RATE_MSB:lmu_pkg::FADE_RATE_LSB];
      fade_en <= I_WR_DATA[lmu_pkg::FADE_EN_POS];
      // A level written mid-fade is dropped; the running target stands
      if (!fade_active) begin
        backlight_level_code <= I_WR_DATA[lmu_pkg::LEVEL_MSB:lmu_pkg::LEVEL_LSB];
      end
    end
  end

  // Sink enable register
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sink_enable_bits <= lmu_pkg::RST_SINK_EN[lmu_pkg::SINK_EN_MSB:lmu_pkg::SINK_EN_LSB];
    end else if (!chip_en) begin
      sink_enable_bits <= lmu_pkg::RST_SINK_EN[lmu_pkg::SINK_EN_MSB:lmu_pkg::SINK_EN_LSB];
    end else if (wr_sink) begin
      sink_enable_bits <= I_WR_DATA[lmu_pkg::SINK_EN_MSB:lmu_pkg::SINK_EN_LSB];
    end
  end

  // Flash setup register
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      flash_timeout_enable <= lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_TMO_EN_POS];
      flash_spot_level_code <=
        lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_CODE_MSB:lmu_pkg::FLASH_CODE_LSB];
      flash_range_select <= lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_RANGE_POS];
    end else if (!chip_en) begin
      flash_timeout_enable <= lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_TMO_EN_POS];
      flash_spot_level_code <=
        lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_CODE_MSB:lmu_pkg::FLASH_CODE_LSB];
      flash_range_select <= lmu_pkg::RST_FLASH_SETUP[lmu_pkg::FLASH_RANGE_POS];
    end else if (wr_flash) begin
      flash_timeout_enable <= I_WR_DATA[lmu_pkg::FLASH_TMO_EN_POS];
      flash_spot_level_code <= I_WR_DATA[lmu_pkg::FLASH_CODE_MSB:lmu_pkg::FLASH_CODE_LSB];
      flash_range_select <= I_WR_DATA[lmu_pkg::FLASH_RANGE_POS];
    end
  end

  // Regulator voltage register
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      reg_a_voltage_code <= lmu_pkg::RST_REG_VOLT[lmu_pkg::REG_A_MSB:lmu_pkg::REG_A_LSB];
      reg_b_voltage_code <= lmu_pkg::RST_REG_VOLT[lmu_pkg::REG_B_MSB:lmu_pkg::REG_B_LSB];
    end else if (!chip_en) begin
      reg_a_voltage_code <= lmu_pkg::RST_REG_VOLT[lmu_pkg::REG_A_MSB:lmu_pkg::REG_A_LSB];
      reg_b_voltage_code <= lmu_pkg::RST_REG_VOLT[lmu_pkg::REG_B_MSB:lmu_pkg::REG_B_LSB];
    end else if (wr_volt) begin
      reg_a_voltage_code <= I_WR_DATA[lmu_pkg::REG_A_MSB:lmu_pkg::REG_A_LSB];
      reg_b_voltage_code <= I_WR_DATA[lmu_pkg::REG_B_MSB:lmu_pkg::REG_B_LSB];
    end
  end

  // Step interval from the live rate code, so a change mid-fade takes hold
  // for the step already under way
  always_comb begin
    step_limit = 22'(lmu_pkg::FADE_UNITS_MAX - {1'b0, fade_rate})
      * 22'(P_FADE_UNIT_CYCLES);
  end

  assign step_due = step_cnt >= step_limit - 22'h000001;

  // Interval counter; idle whenever no fade is running
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      step_cnt <= 22'h000000;
    end else if (!chip_en || !fade_active || step_due) begin
      step_cnt <= 22'h000000;
    end else begin
      step_cnt <= step_cnt + 22'h000001;
    end
  end

  // Applied level: follows the code at once without fade, else one count
  // per expired interval toward the code
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      applied_level <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::LEVEL_MSB:lmu_pkg::LEVEL_LSB];
    end else if (!chip_en) begin
      applied_level <= lmu_pkg::RST_LEVEL_FADE[lmu_pkg::LEVEL_MSB:lmu_pkg::LEVEL_LSB];
    end else if (!fade_en) begin
      applied_level <= backlight_level_code;
    end else if (fade_active && step_due) begin
      if (applied_level < backlight_level_code) begin
        applied_level <= applied_level + 5'h01;
      end else begin
        applied_level <= applied_level - 5'h01;
      end
    end
  end

  // Open-circuit latch per sink, cleared by dropping the enable bit or the enable pin.
  // An enable pin clear wins over detection in the same cycle.
  logic [3:0] sink_float;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      sink_float <= 4'h0;
    end else if (!chip_en) begin
      sink_float <= 4'h0;
    end else begin
      for (int i = 0; i < lmu_pkg::NUM_SINKS; i++) begin
        if (sink_enable_bits[i] && sink_open[i]) begin
          sink_float[i] <= 1'b1;
        end else if (!sink_enable_bits[i]) begin
          sink_float[i] <= 1'b0;
        end
      end
    end
  end

  // Flash sink: pin trigger, non-zero code, safety timer not tripped
  logic flash_tripped;
  logic flash_want;
  logic flash_on;
  logic flash_rearm;

  assign flash_want = flash_pin && flash_spot_level_code != 3'h0;
  assign flash_on = flash_want && !flash_tripped && !overtemp && chip_en;
  // Pin low or a cleared code rearms the timer
  assign flash_rearm = !flash_pin || flash_spot_level_code == 3'h0 || !chip_en;

  lmu_flash_timer #(.TIMEOUT_CYCLES(P_FLASH_TIMEOUT_CYCLES)) u_flash_timer (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_enable(flash_timeout_enable),
    .i_active(flash_on),
    .i_rearm(flash_rearm),
    .o_tripped(flash_tripped)
  );

  // Pump protection: limit entered below 2V, left only above 2.5V
  lmu_pkg::lmu_pump_e pump_state;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pump_state <= lmu_pkg::LMU_PUMP_NORMAL;
    end else begin
      unique case (pump_state)
        lmu_pkg::LMU_PUMP_NORMAL: begin
          if (below_2v) begin
            pump_state <= lmu_pkg::LMU_PUMP_LIMIT;
          end
        end
        lmu_pkg::LMU_PUMP_LIMIT: begin
          if (above_2v5 && !below_2v) begin
            pump_state <= lmu_pkg::LMU_PUMP_NORMAL;
          end
        end
      endcase
    end
  end

  // Sink and sleep decisions
  logic [3:0] next_sink_on;
  logic next_sleep;

  always_comb begin
    next_sink_on = 4'h0;
    if (chip_en && !overtemp) begin
      next_sink_on = sink_enable_bits & ~sink_float;
    end
    // Sleep is judged on what is programmed, not on fault-gated outputs
    next_sleep = !chip_en || (sink_enable_bits == 4'h0 && !flash_want);
  end

  // Output flops; everything goes dark during thermal shutdown
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_BACKLIGHT_LEVEL_CODE <= 5'h00;
      O_SINK_ON <= 4'h0;
      O_FLASH_SINK_OUTPUT <= 1'b0;
      O_FLASH_SPOT_LEVEL_CODE <= 3'h0;
      O_FLASH_RANGE_SELECT <= 1'b0;
      O_REG_A_VOLTAGE_CODE <= 4'h0;
      O_REG_B_VOLTAGE_CODE <= 3'h0;
      O_PUMP_RUN <= 1'b0;
      O_PUMP_LIMIT_ACTIVE <= 1'b0;
      O_PUMP_ILIM_HIGH <= 1'b0;
      O_SLEEP <= 1'b1;
      O_FADE_ACTIVE <= 1'b0;
      O_FLASH_TIMED_OUT <= 1'b0;
    end else begin
      O_BACKLIGHT_LEVEL_CODE <= applied_level;
      O_SINK_ON <= next_sink_on;
      O_FLASH_SINK_OUTPUT <= flash_on;
      O_FLASH_SPOT_LEVEL_CODE <= flash_spot_level_code;
      O_FLASH_RANGE_SELECT <= flash_range_select;
      O_REG_A_VOLTAGE_CODE <= (overtemp || !chip_en) ? 4'h0 : reg_a_voltage_code;
      O_REG_B_VOLTAGE_CODE <= (overtemp || !chip_en) ? 3'h0 : reg_b_voltage_code;
      O_PUMP_RUN <= !overvolt && !overtemp && !next_sleep;
      O_PUMP_LIMIT_ACTIVE <= pump_state == lmu_pkg::LMU_PUMP_LIMIT;
      O_PUMP_ILIM_HIGH <= flash_on;
      O_SLEEP <= next_sleep;
      O_FADE_ACTIVE <= fade_active;
      O_FLASH_TIMED_OUT <= flash_tripped;
    end
  end

  // Register read-back; unused upper bits and unmapped offsets read zero
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    unique case (I_RD_ADDR)
      lmu_pkg::OFS_LEVEL_FADE: begin
        next_rd_data = {fade_rate, fade_en, backlight_level_code};
      end
      lmu_pkg::OFS_SINK_EN: begin
        next_rd_data = {4'h0, sink_enable_bits};
      end
      lmu_pkg::OFS_FLASH_SETUP: begin
        next_rd_data = {3'h0, flash_timeout_enable, flash_spot_level_code,
                        flash_range_select};
      end
      lmu_pkg::OFS_REG_VOLT: begin
        next_rd_data = {1'b0, reg_b_voltage_code, reg_a_voltage_code};
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RD_DATA <= 8'h00;
    end else begin
      O_RD_DATA <= next_rd_data;
    end
  end
endmodule
`default_nettype wire

// File: bench/lmu_ctrl_props.sv
// Port-level checker for the LED driver control block
`timescale 1ns/1ps
`default_nettype none
module lmu_ctrl_props (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CHIP_EN,
  input wire logic I_OVERTEMP_GUARD,
  input wire logic I_OUTPUT_OVERVOLTAGE_GUARD,
  input wire logic I_PUMP_OUTPUT_BELOW_2V,
  input wire logic I_PUMP_OUTPUT_ABOVE_2V5,
  input wire logic [3:0] I_SINK_OPEN,
  input wire logic [4:0] O_BACKLIGHT_LEVEL_CODE,
  input wire logic [3:0] O_SINK_ON,
  input wire logic O_FLASH_SINK_OUTPUT,
  input wire logic [3:0] O_REG_A_VOLTAGE_CODE,
  input wire logic [2:0] O_REG_B_VOLTAGE_CODE,
  input wire logic O_PUMP_RUN,
  input wire logic O_PUMP_LIMIT_ACTIVE,
  input wire logic O_PUMP_ILIM_HIGH,
  input wire logic O_SLEEP,
  input wire logic O_FADE_ACTIVE,
  input wire logic O_FLASH_TIMED_OUT
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // Pins cross a synchroniser, so held-level checks wait for 7 edges
  logic [2:0] c_ot, c_ov, c_lo, c_hi, c_en, c_op;
  logic [3:0] op_q;
  logic [4:0] lvl_q;
  logic [4:0] lvl_d;
  assign lvl_d = O_BACKLIGHT_LEVEL_CODE - lvl_q;
  function automatic logic [2:0] nx(input logic [2:0] c, input logic k);
    return !k ? 3'h0 : (c == 3'h7) ? c : c + 3'h1;
  endfunction
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      {c_ot, c_ov, c_lo, c_hi, c_en, c_op} <= '0;
      op_q <= 4'h0;
      lvl_q <= 5'h00;
    end else begin
      c_ot <= nx(c_ot, I_OVERTEMP_GUARD);
      c_ov <= nx(c_ov, I_OUTPUT_OVERVOLTAGE_GUARD);
      c_lo <= nx(c_lo, I_PUMP_OUTPUT_BELOW_2V);
      c_hi <= nx(c_hi, !I_PUMP_OUTPUT_ABOVE_2V5);
      c_en <= nx(c_en, !I_CHIP_EN);
      c_op <= nx(c_op, (I_SINK_OPEN != 4'h0) && (I_SINK_OPEN == op_q));
      op_q <= I_SINK_OPEN;
      lvl_q <= O_BACKLIGHT_LEVEL_CODE;
    end
  end
  a_overtemp_off: assert property (c_ot == 3'h7 |-> O_SINK_ON == 4'h0
    && !O_FLASH_SINK_OUTPUT
    && O_REG_A_VOLTAGE_CODE == 4'h0 && O_REG_B_VOLTAGE_CODE == 3'h0)
    else $error("outputs active during over-temperature");
  a_ovp_pump_stop: assert property (c_ov == 3'h7 |-> !O_PUMP_RUN)
    else $error("pump runs during over-voltage");
  a_limit_enter: assert property (c_lo == 3'h7 |-> O_PUMP_LIMIT_ACTIVE)
    else $error("current limit not entered");
  a_limit_hold: assert property (c_hi == 3'h7 |-> !$fell(O_PUMP_LIMIT_ACTIVE))
    else $error("current limit left below upper level");
  a_ilim_flash: assert property (O_PUMP_ILIM_HIGH == O_FLASH_SINK_OUTPUT)
    else $error("pump limit does not follow flash sink");
  a_timeout_off: assert property (O_FLASH_TIMED_OUT && $past(O_FLASH_TIMED_OUT)
    |-> !O_FLASH_SINK_OUTPUT)
    else $error("flash on after timeout");
  a_sleep_pump: assert property (O_SLEEP |-> !O_PUMP_RUN)
    else $error("pump runs in sleep");
  a_en_clear: assert property (c_en == 3'h7 |-> O_SINK_ON == 4'h0
    && O_BACKLIGHT_LEVEL_CODE == 5'h00 && O_SLEEP)
    else $error("outputs active with enable low");
  a_open_off: assert property (c_op == 3'h7 |-> (O_SINK_ON & I_SINK_OPEN) == 4'h0)
    else $error("open sink still active");
  a_fade_step: assert property ($past(O_FADE_ACTIVE, 2) && $past(O_FADE_ACTIVE)
    && O_FADE_ACTIVE |-> lvl_d inside {5'h00, 5'h01, 5'h1f})
    else $error("fade moved more than one code");
  c_fade: cover property ($rose(O_FADE_ACTIVE));
  c_flash: cover property ($rose(O_FLASH_SINK_OUTPUT));
  c_timeout: cover property ($rose(O_FLASH_TIMED_OUT));
  c_limit: cover property ($fell(O_PUMP_LIMIT_ACTIVE));
endmodule
bind lmu_ctrl lmu_ctrl_props lmu_ctrl_props_inst (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
  .I_CHIP_EN(I_CHIP_EN), .I_OVERTEMP_GUARD(I_OVERTEMP_GUARD),
  .I_OUTPUT_OVERVOLTAGE_GUARD(I_OUTPUT_OVERVOLTAGE_GUARD),
  .I_PUMP_OUTPUT_BELOW_2V(I_PUMP_OUTPUT_BELOW_2V),
  .I_PUMP_OUTPUT_ABOVE_2V5(I_PUMP_OUTPUT_ABOVE_2V5), .I_SINK_OPEN(I_SINK_OPEN),
  .O_BACKLIGHT_LEVEL_CODE(O_BACKLIGHT_LEVEL_CODE), .O_SINK_ON(O_SINK_ON),
  .O_FLASH_SINK_OUTPUT(O_FLASH_SINK_OUTPUT), .O_REG_A_VOLTAGE_CODE(O_REG_A_VOLTAGE_CODE),
  .O_REG_B_VOLTAGE_CODE(O_REG_B_VOLTAGE_CODE), .O_PUMP_RUN(O_PUMP_RUN),
  .O_PUMP_LIMIT_ACTIVE(O_PUMP_LIMIT_ACTIVE), .O_PUMP_ILIM_HIGH(O_PUMP_ILIM_HIGH),
  .O_SLEEP(O_SLEEP), .O_FADE_ACTIVE(O_FADE_ACTIVE), .O_FLASH_TIMED_OUT(O_FLASH_TIMED_OUT));
`default_nettype wire

// File: bench/lmu_host_model.sv
// Behavioural host that writes and reads the control registers
`timescale 1ns/1ps
`default_nettype none
module lmu_host_model (
  input wire logic i_clk,
  output logic o_wr_stb,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  initial begin
    o_wr_stb = 1'b0;
    o_wr_addr = 8'h00;
    o_wr_data = 8'h00;
    o_rd_addr = 8'h00;
  end
  // Callers pass unused upper bits as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_wr_stb = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b0;
    // Idle bus shows the inverse so stale data is never taken for a write
    o_wr_addr = ~a;
    o_wr_data = ~d;
    // Let an edge pass so a following write never re-raises the strobe at once
    @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_rd_addr = a;
    repeat (2) @(posedge i_clk);
    #1;
    d = i_rd_data;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_lmu_ctrl.sv
// Self-checking testbench for the LED driver control block
`timescale 1ns/1ps
`default_nettype none
module tb_lmu_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, trig = 1'b0, ot = 1'b0, ov = 1'b0, lo = 1'b0, hi = 1'b1;
  logic [3:0] opn = 4'h0;
  logic wr_stb;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [4:0] lvl;
  logic [3:0] sink_on, rega;
  logic [2:0] fcode, regb;
  logic fl, frange, prun, plim, pil, slp, fact, fto;
  int fail_count = 0;
  int compares = 0;
  always #50 clk = ~clk;
  lmu_ctrl #(.P_FADE_UNIT_CYCLES(10), .P_FLASH_TIMEOUT_CYCLES(50)) lmu_ctrl_inst (
    .I_REF_CLK(clk), .I_RST(rst), .I_WR_STB(wr_stb), .I_WR_ADDR(wr_addr),
    .I_WR_DATA(wr_data), .I_RD_ADDR(rd_addr), .O_RD_DATA(rd_data), .I_CHIP_EN(en),
    .I_FLASH_TRIGGER_PIN(trig), .I_OVERTEMP_GUARD(ot), .I_OUTPUT_OVERVOLTAGE_GUARD(ov),
    .I_PUMP_OUTPUT_BELOW_2V(lo), .I_PUMP_OUTPUT_ABOVE_2V5(hi), .I_SINK_OPEN(opn),
    .O_BACKLIGHT_LEVEL_CODE(lvl), .O_SINK_ON(sink_on), .O_FLASH_SINK_OUTPUT(fl),
    .O_FLASH_SPOT_LEVEL_CODE(fcode), .O_FLASH_RANGE_SELECT(frange),
    .O_REG_A_VOLTAGE_CODE(rega), .O_REG_B_VOLTAGE_CODE(regb), .O_PUMP_RUN(prun),
    .O_PUMP_LIMIT_ACTIVE(plim), .O_PUMP_ILIM_HIGH(pil), .O_SLEEP(slp),
    .O_FADE_ACTIVE(fact), .O_FLASH_TIMED_OUT(fto));
  lmu_host_model lmu_host_model_inst (.i_clk(clk), .o_wr_stb(wr_stb), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_addr(rd_addr), .i_rd_data(rd_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lmu_host_model_inst.wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    lmu_host_model_inst.rd(a, d);
    chk(d, exp);
  endtask
  task automatic wait_lvl(input logic [4:0] v, output int n);
    n = 0;
    while (lvl !== v && n < 400) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_regs();
    rdc(lmu_pkg::OFS_LEVEL_FADE, lmu_pkg::RST_LEVEL_FADE);
    rdc(lmu_pkg::OFS_SINK_EN, lmu_pkg::RST_SINK_EN);
    rdc(lmu_pkg::OFS_FLASH_SETUP, lmu_pkg::RST_FLASH_SETUP);
    rdc(lmu_pkg::OFS_REG_VOLT, lmu_pkg::RST_REG_VOLT);
    wr(8'h04, 8'h5a);
    rdc(8'h04, 8'h00);
    wr(lmu_pkg::OFS_REG_VOLT, 8'h45);
    rdc(lmu_pkg::OFS_REG_VOLT, 8'h45);
    chk({4'h0, rega}, 8'h05);
    chk({5'h00, regb}, 8'h04);
  endtask
  task automatic t_direct();
    wr(lmu_pkg::OFS_SINK_EN, 8'h05);
    wr(lmu_pkg::OFS_LEVEL_FADE, 8'h13);
    tick(2);
    chk({3'h0, lvl}, 8'h13);
    chk({4'h0, sink_on}, 8'h05);
    wr(lmu_pkg::OFS_SINK_EN, 8'h0f);
  endtask
  task automatic t_fade_rates();
    int n;
    for (int r = 0; r < 4; r++) begin
      wr(lmu_pkg::OFS_LEVEL_FADE, 8'h00);
      tick(2);
      wr(lmu_pkg::OFS_LEVEL_FADE, {r[1:0], 1'b1, 5'h02});
      wait_lvl(5'h01, n);
      wait_lvl(5'h02, n);
      chk(n[7:0], 8'((4 - r) * 10));
      // Next level write only once the fade has ended
      tick(4);
      chk({7'h00, fact}, 8'h00);
      chk({3'h0, lvl}, 8'h02);
    end
  endtask
  task automatic t_fade_mid();
    int n;
    wr(lmu_pkg::OFS_LEVEL_FADE, 8'h00);
    tick(2);
    wr(lmu_pkg::OFS_LEVEL_FADE, 8'h2a);
    wait_lvl(5'h01, n);
    chk({7'h00, fact}, 8'h01);
    // Deliberate level write mid-fade: the rate and enable fields land, the level is dropped
    wr(lmu_pkg::OFS_LEVEL_FADE, 8'hff);
    wait_lvl(5'h02, n);
    wait_lvl(5'h03, n);
    chk(n[7:0], 8'h0a);
    wr(lmu_pkg::OFS_LEVEL_FADE, 8'h00);
    tick(3);
    chk({3'h0, lvl}, 8'h0a);
    chk({7'h00, fact}, 8'h00);
    rdc(lmu_pkg::OFS_LEVEL_FADE, 8'h0a);
  endtask
  task automatic t_protect();
    ot = 1'b1;
    tick(8);
    chk({4'h0, sink_on}, 8'h00);
    chk({4'h0, rega}, 8'h00);
    rdc(lmu_pkg::OFS_SINK_EN, 8'h0f);
    ot = 1'b0;
    tick(8);
    chk({4'h0, sink_on}, 8'h0f);
    chk({4'h0, rega}, 8'h05);
    ov = 1'b1;
    tick(8);
    chk({7'h00, prun}, 8'h00);
    ov = 1'b0;
    tick(8);
    chk({7'h00, prun}, 8'h01);
    lo = 1'b1;
    hi = 1'b0;
    tick(8);
    chk({7'h00, plim}, 8'h01);
    lo = 1'b0;
    tick(8);
    chk({7'h00, plim}, 8'h01);
    hi = 1'b1;
    tick(8);
    chk({7'h00, plim}, 8'h00);
  endtask
  task automatic t_open();
    opn = 4'h4;
    // Held past the checker's settle count so its open-sink check bites
    tick(10);
    chk({4'h0, sink_on}, 8'h0b);
    opn = 4'h0;
    tick(8);
    chk({4'h0, sink_on}, 8'h0b);
    wr(lmu_pkg::OFS_SINK_EN, 8'h0b);
    tick(2);
    wr(lmu_pkg::OFS_SINK_EN, 8'h0f);
    tick(2);
    chk({4'h0, sink_on}, 8'h0f);
  endtask
  task automatic t_flash();
    wr(lmu_pkg::OFS_FLASH_SETUP, 8'h13);
    trig = 1'b1;
    tick(8);
    chk({6'h00, fl, pil}, 8'h03);
    chk({4'h0, fcode, frange}, 8'h03);
    tick(60);
    chk({6'h00, fl, fto}, 8'h01);
    chk({7'h00, pil}, 8'h00);
    trig = 1'b0;
    tick(8);
    chk({7'h00, fto}, 8'h00);
    wr(lmu_pkg::OFS_FLASH_SETUP, 8'h03);
    trig = 1'b1;
    tick(80);
    chk({7'h00, fl}, 8'h01);
    trig = 1'b0;
    tick(8);
    chk({7'h00, fl}, 8'h00);
  endtask
  task automatic t_sleep_en();
    wr(lmu_pkg::OFS_SINK_EN, 8'h00);
    tick(3);
    chk({6'h00, slp, prun}, 8'h02);
    en = 1'b0;
    tick(8);
    chk({3'h0, lvl}, 8'h00);
    en = 1'b1;
    tick(8);
    rdc(lmu_pkg::OFS_REG_VOLT, lmu_pkg::RST_REG_VOLT);
    rdc(lmu_pkg::OFS_LEVEL_FADE, lmu_pkg::RST_LEVEL_FADE);
    rdc(lmu_pkg::OFS_FLASH_SETUP, lmu_pkg::RST_FLASH_SETUP);
  endtask
  task automatic print_verdict();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    en = 1'b1;
    tick(8);
    t_regs();
    t_direct();
    t_fade_rates();
    t_fade_mid();
    t_protect();
    t_open();
    t_flash();
    t_sleep_en();
    print_verdict();
  end
  // Whole run is well under a thousand cycles; this leaves a wide margin
  initial begin
    #3000000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
